// ### shared/asp_pkg.sv
package asp_pkg;
   // Register indices; byte address is four times the index
   localparam logic [13:0] IDX_CTRL_ONE = 14'h0f98;
   localparam logic [13:0] IDX_STATUS   = 14'h0f98;
   localparam logic [13:0] IDX_CTRL_TWO = 14'h0f99;
   localparam logic [13:0] IDX_BUFFER   = 14'h0f9a;
   // Control one fields, then the control two stop field
   localparam int CTL_TXEN   = 7;
   localparam int CTL_RXEN   = 6;
   localparam int CTL_TXSTOP = 5;
   localparam int CTL_EVEN   = 4;
   localparam int CTL_PAR    = 3;
   localparam int CTL_BAUD   = 0;
   localparam int CT2_RXSTOP = 0;
   // Status fields
   localparam int ST_PF    = 7;
   localparam int ST_FF    = 6;
   localparam int ST_OVR   = 5;
   localparam int ST_FULL  = 4;
   localparam int ST_DONE  = 3;
   localparam int ST_EMPTY = 2;
   // Reset values
   localparam logic [7:0] CTRL_ONE_RST = 8'h00;
   localparam logic       RXSTOP_RST   = 1'b0;
   localparam logic       EMPTY_RST    = 1'b1;
   localparam logic       DONE_RST     = 1'b1;
   // Receiver clock dividers: 13, 26, 52, 104, 208, 416, 96
   localparam logic [8:0] DIV_0 = 9'h00d;
   localparam logic [8:0] DIV_1 = 9'h01a;
   localparam logic [8:0] DIV_2 = 9'h034;
   localparam logic [8:0] DIV_3 = 9'h068;
   localparam logic [8:0] DIV_4 = 9'h0d0;
   localparam logic [8:0] DIV_5 = 9'h1a0;
   localparam logic [8:0] DIV_7 = 9'h060;
   localparam logic [2:0] BAUD_TIMER = 3'h6;
   // Receiver clock ticks within one bit, then last data bit and bus responses
   localparam logic [3:0] PHASE_LAST = 4'hf;
   localparam logic [3:0] SAMPLE_A   = 4'h7;
   localparam logic [3:0] SAMPLE_B   = 4'h8;
   localparam logic [3:0] SAMPLE_C   = 4'h9;
   localparam logic [2:0] BIT_LAST   = 3'h7;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} asp_tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} asp_rx_state_t;
endpackage : asp_pkg

// ### rtl/asp_baud_tick.sv
module asp_baud_tick (
   input  wire logic       clk,       // System clock
   input  wire logic       rst,       // Synchronous reset
   input  wire logic       ce,        // Clock enable
   input  wire logic [2:0] baudSel,   // Divider code
   input  wire logic       timerFive, // Timer pulse, same clock
   output logic            tick       // Receiver clock tick
);
   logic [8:0] cnt;
   logic [8:0] div;

   // Divider lookup per code
   always_comb begin
      case (baudSel)
         3'h0:    div = asp_pkg::DIV_0;
         3'h1:    div = asp_pkg::DIV_1;
         3'h2:    div = asp_pkg::DIV_2;
         3'h3:    div = asp_pkg::DIV_3;
         3'h4:    div = asp_pkg::DIV_4;
         3'h5:    div = asp_pkg::DIV_5;
         default: div = asp_pkg::DIV_7;
      endcase
   end

   // Free running divider; timer code bypasses it
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt  <= 9'h000;
         tick <= 1'b0;
      end else if (ce) begin
         if (baudSel == asp_pkg::BAUD_TIMER) begin
            cnt  <= 9'h000;
            tick <= timerFive;
         end else if (cnt >= div - 9'h001) begin
            cnt  <= 9'h000;
            tick <= 1'b1;
         end else begin
            cnt  <= cnt + 9'h001;
            tick <= 1'b0;
         end
      end
   end
endmodule : asp_baud_tick

// ### rtl/asp_rx_sample.sv
module asp_rx_sample (
   input  wire logic       clk,         // System clock
   input  wire logic       rst,         // Synchronous reset
   input  wire logic       ce,          // Clock enable
   input  wire logic       serialInPin, // Line input, asynchronous
   input  wire logic       tick,        // Receiver clock tick
   input  wire logic [3:0] phase,       // Tick number within bit
   output logic            lineNow,     // Synchronised line
   output logic            vote         // Majority of three samples
);
   logic syncA;
   logic s7;
   logic s8;

   // Two stage synchroniser; idle line is high
   always_ff @(posedge clk) begin
      if (rst) begin
         syncA   <= 1'b1;
         lineNow <= 1'b1;
      end else if (ce) begin
         syncA   <= serialInPin;
         lineNow <= syncA;
      end
   end

   // Hold the first two samples of the bit
   always_ff @(posedge clk) begin
      if (rst) begin
         s7 <= 1'b1;
         s8 <= 1'b1;
      end else if (ce && tick) begin
         if (phase == asp_pkg::SAMPLE_A) s7 <= lineNow;
         if (phase == asp_pkg::SAMPLE_B) s8 <= lineNow;
      end
   end

   // Valid at the third sample tick
   assign vote = (s7 & s8) | (s7 & lineNow) | (s8 & lineNow);
endmodule : asp_rx_sample

// ### rtl/asp_async_port.sv
module asp_async_port (
   input  wire logic        clk,          // System clock, 100 MHz
   input  wire logic        rst,          // Synchronous reset
   input  wire logic        ce,           // Clock enable
   input  wire logic        timerFive,    // Timer pulse for code 110
   input  wire logic        serialInPin,  // Serial receive line
   output logic             serialOutPin, // Serial transmit line
   output logic             txEventIrq,   // Transmit start pulse
   output logic             rxEventIrq,   // Receive done pulse when the buffer is not full
   input  wire logic [15:0] awaddr,       // AXI write address
   input  wire logic [2:0]  awprot,       // Unused
   input  wire logic        awvalid,      // AXI
   output logic             awready,      // AXI
   input  wire logic [31:0] wdata,        // AXI write data
   input  wire logic [3:0]  wstrb,        // AXI byte enables
   input  wire logic        wvalid,       // AXI
   output logic             wready,       // AXI
   output logic [1:0]       bresp,        // AXI
   output logic             bvalid,       // AXI
   input  wire logic        bready,       // AXI
   input  wire logic [15:0] araddr,       // AXI read address
   input  wire logic [2:0]  arprot,       // Unused
   input  wire logic        arvalid,      // AXI
   output logic             arready,      // AXI
   output logic [31:0]      rdata,        // AXI read data
   output logic [1:0]       rresp,        // AXI
   output logic             rvalid,       // AXI
   input  wire logic        rready        // AXI
);
   logic [15:0] awAddr;
   logic        awHave;
   logic [7:0]  wByte;
   logic        wLane;
   logic        wHave;
   logic        writeGo;
   logic        readGo;
   logic [7:0]  ctrlOne;
   logic        rxStop;
   logic        txArm;
   logic        rxArm;
   logic        ovrSeen;
   logic        statusRead;
   logic        bufRead;
   logic        bufWr;
   logic        rxClr;
   logic [7:0]  txHold;
   logic        txEmpty;
   logic        txDone;
   logic        txLoad;
   logic        txFinish;
   logic [7:0]  rxBuf;
   logic        rxFull;
   logic        overrun;
   logic        parFault;
   logic        frameFault;
   logic        rxDone;
   logic        rxAccept;
   logic        tick;
   logic        lineNow;
   logic        vote;
   logic [7:0]  status;

   asp_pkg::asp_tx_state_t txState;
   logic [3:0]  txPhase;
   logic [2:0]  txBit;
   logic        txStopIdx;
   logic [7:0]  txShift;
   logic        txPar;

   asp_pkg::asp_rx_state_t rxState;
   logic [3:0]  rxPhase;
   logic [2:0]  rxBit;
   logic        rxStopIdx;
   logic [7:0]  rxShift;
   logic        rxParBit;
   logic        stopBad;
   logic        frameBad;
   logic        parBad;

   // Word index of a byte address
   function automatic logic [13:0] regIdx(input logic [15:0] a);
      regIdx = a[15:2];
   endfunction : regIdx

   function automatic logic mapped(input logic [15:0] a);
      mapped = (regIdx(a) == asp_pkg::IDX_CTRL_ONE) ||
               (regIdx(a) == asp_pkg::IDX_CTRL_TWO) ||
               (regIdx(a) == asp_pkg::IDX_BUFFER);
   endfunction : mapped

   asp_baud_tick u_tick (
      .clk       (clk),
      .rst       (rst),
      .ce        (ce),
      .baudSel   (ctrlOne[asp_pkg::CTL_BAUD +: 3]),
      .timerFive (timerFive),
      .tick      (tick)
   );

   asp_rx_sample u_sample (
      .clk         (clk),
      .rst         (rst),
      .ce          (ce),
      .serialInPin (serialInPin),
      .tick        (tick),
      .phase       (rxPhase),
      .lineNow     (lineNow),
      .vote        (vote)
   );

   // Handshakes; nothing is taken while the clock enable is low
   assign awready = ce & ~awHave;
   assign wready  = ce & ~wHave;
   assign arready = ce & ~rvalid;
   assign writeGo = ce & awHave & wHave & ~bvalid;
   assign readGo  = arvalid & arready;

   // Register side effects
   assign statusRead = readGo && regIdx(araddr) == asp_pkg::IDX_STATUS;
   assign bufRead    = readGo && regIdx(araddr) == asp_pkg::IDX_BUFFER;
   assign bufWr      = writeGo && wLane && regIdx(awAddr) == asp_pkg::IDX_BUFFER;
   assign rxClr      = bufRead & rxArm;

   // Address and data are taken in either order
   always_ff @(posedge clk) begin
      if (rst) begin
         awHave <= 1'b0;
         awAddr <= 16'h0000;
      end else if (ce) begin
         if (awvalid && awready) begin
            awHave <= 1'b1;
            awAddr <= awaddr;
         end else if (writeGo) begin
            awHave <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wHave <= 1'b0;
         wByte <= 8'h00;
         wLane <= 1'b0;
      end else if (ce) begin
         if (wvalid && wready) begin
            wHave <= 1'b1;
            wByte <= wdata[7:0];
            wLane <= wstrb[0];
         end else if (writeGo) begin
            wHave <= 1'b0;
         end
      end
   end

   // Write response
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp  <= asp_pkg::RESP_OKAY;
      end else if (ce) begin
         if (writeGo) begin
            bvalid <= 1'b1;
            bresp  <= mapped(awAddr) ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
         end else if (bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Control registers are write only; control one's index reads back status, control two reads as zero
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrlOne <= asp_pkg::CTRL_ONE_RST;
         rxStop  <= asp_pkg::RXSTOP_RST;
      end else if (writeGo && wLane) begin
         if (regIdx(awAddr) == asp_pkg::IDX_CTRL_ONE) ctrlOne <= wByte;
         if (regIdx(awAddr) == asp_pkg::IDX_CTRL_TWO) rxStop <= wByte[asp_pkg::CT2_RXSTOP];
      end
   end

   always_comb begin
      status = 8'h00;
      status[asp_pkg::ST_PF]    = parFault;
      status[asp_pkg::ST_FF]    = frameFault;
      status[asp_pkg::ST_OVR]   = overrun;
      status[asp_pkg::ST_FULL]  = rxFull;
      status[asp_pkg::ST_DONE]  = txDone;
      status[asp_pkg::ST_EMPTY] = txEmpty;
   end

   // Read data is registered at the address handshake
   always_ff @(posedge clk) begin
      if (rst) begin
         rvalid <= 1'b0;
         rdata  <= 32'h00000000;
         rresp  <= asp_pkg::RESP_OKAY;
      end else if (ce) begin
         if (readGo) begin
            rvalid <= 1'b1;
            rresp  <= mapped(araddr) ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
            case (regIdx(araddr))
               asp_pkg::IDX_STATUS: rdata <= {24'h000000, status};
               asp_pkg::IDX_BUFFER: rdata <= {24'h000000, rxBuf};
               default:             rdata <= 32'h00000000;
            endcase
         end else if (rready) begin
            rvalid <= 1'b0;
         end
      end
   end

   // Status read arms one buffer access on each side
   always_ff @(posedge clk) begin
      if (rst) begin
         txArm   <= 1'b0;
         rxArm   <= 1'b0;
         ovrSeen <= 1'b0;
      end else if (ce) begin
         if (statusRead) begin
            txArm   <= 1'b1;
            rxArm   <= 1'b1;
            ovrSeen <= overrun;
         end else begin
            if (bufWr) txArm <= 1'b0;
            if (bufRead) rxArm <= 1'b0;
         end
      end
   end

   // Transmit holding buffer and its flags
   always_ff @(posedge clk) begin
      if (rst) begin
         txHold  <= 8'h00;
         txEmpty <= asp_pkg::EMPTY_RST;
         txDone  <= asp_pkg::DONE_RST;
         txEventIrq <= 1'b0;
      end else if (ce) begin
         txEventIrq <= txLoad;
         if (txLoad) txEmpty <= 1'b1;
         else if (bufWr && txArm) begin
            txEmpty <= 1'b0;
            txHold  <= wByte;
         end
         if (txLoad) txDone <= 1'b0;
         else if (txFinish && txEmpty) txDone <= 1'b1;
      end
   end

   // Start only from idle, so a disable waits for the frame end
   assign txLoad = txState == asp_pkg::TX_IDLE && !txEmpty && ctrlOne[asp_pkg::CTL_TXEN];
   assign txFinish = tick && txState == asp_pkg::TX_STOP && txPhase == asp_pkg::PHASE_LAST &&
                     txStopIdx == ctrlOne[asp_pkg::CTL_TXSTOP];

   // Transmit framing, sixteen ticks per bit
   always_ff @(posedge clk) begin
      if (rst) begin
         txState      <= asp_pkg::TX_IDLE;
         txPhase      <= 4'h0;
         txBit        <= 3'h0;
         txStopIdx    <= 1'b0;
         txShift      <= 8'h00;
         txPar        <= 1'b0;
         serialOutPin <= 1'b1;
      end else if (ce) begin
         case (txState)
            asp_pkg::TX_IDLE: begin
               serialOutPin <= 1'b1;
               if (txLoad) begin
                  txShift      <= txHold;
                  txPar        <= ^txHold ^ ~ctrlOne[asp_pkg::CTL_EVEN];
                  txPhase      <= 4'h0;
                  serialOutPin <= 1'b0;
                  txState      <= asp_pkg::TX_START;
               end
            end
            default: begin
               if (tick) begin
                  txPhase <= txPhase + 4'h1;
                  if (txPhase == asp_pkg::PHASE_LAST) begin
                     case (txState)
                        asp_pkg::TX_START: begin
                           txBit        <= 3'h0;
                           serialOutPin <= txShift[0];
                           txShift      <= txShift >> 1;
                           txState      <= asp_pkg::TX_DATA;
                        end
                        asp_pkg::TX_DATA: begin
                           if (txBit != asp_pkg::BIT_LAST) begin
                              txBit        <= txBit + 3'h1;
                              serialOutPin <= txShift[0];
                              txShift      <= txShift >> 1;
                           end else if (ctrlOne[asp_pkg::CTL_PAR]) begin
                              serialOutPin <= txPar;
                              txState      <= asp_pkg::TX_PAR;
                           end else begin
                              serialOutPin <= 1'b1;
                              txStopIdx    <= 1'b0;
                              txState      <= asp_pkg::TX_STOP;
                           end
                        end
                        asp_pkg::TX_PAR: begin
                           serialOutPin <= 1'b1;
                           txStopIdx    <= 1'b0;
                           txState      <= asp_pkg::TX_STOP;
                        end
                        default: begin
                           if (txFinish) txState <= asp_pkg::TX_IDLE;
                           else txStopIdx <= 1'b1;
                        end
                     endcase
                  end
               end
            end
         endcase
      end
   end

   // Receive completes at the vote of the last stop bit
   assign rxDone   = tick && rxState == asp_pkg::RX_STOP && rxPhase == asp_pkg::SAMPLE_C &&
                     rxStopIdx == rxStop;
   assign rxAccept = rxDone & ~rxFull;
   assign frameBad = stopBad | ~vote;
   assign parBad   = ctrlOne[asp_pkg::CTL_PAR] &&
                     (rxParBit != (^rxShift ^ ~ctrlOne[asp_pkg::CTL_EVEN]));

   // Receive framing
   always_ff @(posedge clk) begin
      if (rst) begin
         rxState   <= asp_pkg::RX_IDLE;
         rxPhase   <= 4'h0;
         rxBit     <= 3'h0;
         rxStopIdx <= 1'b0;
         rxShift   <= 8'h00;
         rxParBit  <= 1'b0;
         stopBad   <= 1'b0;
      end else if (ce && tick) begin
         case (rxState)
            asp_pkg::RX_IDLE: begin
               // Enable and overrun only gate a new start
               if (ctrlOne[asp_pkg::CTL_RXEN] && !overrun && !lineNow) begin
                  rxPhase <= 4'h1;
                  stopBad <= 1'b0;
                  rxState <= asp_pkg::RX_START;
               end
            end
            default: begin
               rxPhase <= rxPhase + 4'h1;
               if (rxPhase == asp_pkg::SAMPLE_C) begin
                  case (rxState)
                     asp_pkg::RX_START: if (vote) rxState <= asp_pkg::RX_IDLE;
                     asp_pkg::RX_DATA:  rxShift <= {vote, rxShift[7:1]};
                     asp_pkg::RX_PAR:   rxParBit <= vote;
                     default: begin
                        if (!vote) stopBad <= 1'b1;
                        if (rxDone) rxState <= asp_pkg::RX_IDLE;
                     end
                  endcase
               end else if (rxPhase == asp_pkg::PHASE_LAST) begin
                  case (rxState)
                     asp_pkg::RX_START: begin
                        rxBit   <= 3'h0;
                        rxState <= asp_pkg::RX_DATA;
                     end
                     asp_pkg::RX_DATA: begin
                        rxBit <= rxBit + 3'h1;
                        if (rxBit == asp_pkg::BIT_LAST) begin
                           rxStopIdx <= 1'b0;
                           rxState   <= ctrlOne[asp_pkg::CTL_PAR] ? asp_pkg::RX_PAR
                                                                 : asp_pkg::RX_STOP;
                        end
                     end
                     asp_pkg::RX_PAR: rxState <= asp_pkg::RX_STOP;
                     default:         rxStopIdx <= 1'b1;
                  endcase
               end
            end
         endcase
      end
   end

   // Receive buffer and flags; a set beats a same cycle clear
   always_ff @(posedge clk) begin
      if (rst) begin
         rxBuf      <= 8'h00;
         rxFull     <= 1'b0;
         overrun    <= 1'b0;
         parFault   <= 1'b0;
         frameFault <= 1'b0;
         rxEventIrq <= 1'b0;
      end else if (ce) begin
         rxEventIrq <= rxAccept;
         if (rxAccept) begin
            rxBuf  <= rxShift;
            rxFull <= 1'b1;
         end else if (rxClr) rxFull <= 1'b0;
         if (rxDone && rxFull) overrun <= 1'b1;
         else if (rxClr && ovrSeen) overrun <= 1'b0;
         if (rxAccept && parBad) parFault <= 1'b1;
         else if (rxClr) parFault <= 1'b0;
         if (rxAccept && frameBad) frameFault <= 1'b1;
         else if (rxClr) frameFault <= 1'b0;
      end
   end
endmodule : asp_async_port

// ### tb/asp_async_port_props.sv
module asp_async_port_props (
   input wire logic        clk,          // Clock
   input wire logic        rst,          // Reset
   input wire logic        serialOutPin, // Line out
   input wire logic        txEventIrq,   // Tx pulse
   input wire logic        rxEventIrq,   // Rx pulse
   input wire logic        arvalid,      // AXI
   input wire logic        arready,      // AXI
   input wire logic        rvalid,       // AXI
   input wire logic        rready,       // AXI
   input wire logic [31:0] rdata,        // AXI
   input wire logic [1:0]  rresp,        // AXI
   input wire logic        bvalid,       // AXI
   input wire logic        bready        // AXI
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Event pulses last one cycle; a stuck pulse would flood software
   AST_TX_IRQ_ONE: assert property (txEventIrq |=> !txEventIrq)
      else $error("tx pulse too long");
   AST_RX_IRQ_ONE: assert property (rxEventIrq |=> !rxEventIrq)
      else $error("rx pulse too long");
   AST_START_BIT: assert property (txEventIrq |-> (!serialOutPin) [*8])
      else $error("start bit not low");
   AST_RESET_IDLE: assert property ($fell(rst) |-> serialOutPin && !txEventIrq && !rxEventIrq)
      else $error("not idle after reset");
   // Register bus handshake and read data upper bits
   AST_AR_ANSWER: assert property (arvalid && arready |=> rvalid)
      else $error("read not answered");
   AST_R_DROP: assert property (rvalid && rready |=> !rvalid)
      else $error("rvalid stuck");
   AST_B_DROP: assert property (bvalid && bready |=> !bvalid)
      else $error("bvalid stuck");
   AST_AR_BLOCK: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   AST_R_UPPER: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits set");
   cover property (txEventIrq);
   cover property (rxEventIrq);
   cover property (rvalid && rresp == asp_pkg::RESP_SLVERR);
endmodule : asp_async_port_props

bind asp_async_port asp_async_port_props u_props (.clk, .rst, .serialOutPin, .txEventIrq,
   .rxEventIrq, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .bvalid, .bready);

// ### tb/asp_remote.sv
module asp_remote #(parameter int BIT = 208) (
   input  wire logic clk,          // Clock
   input  wire logic serialOutPin, // From port
   output logic      serialInPin   // To port
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] got;
   int         gotCnt = 0;
   initial serialInPin = 1'b1;
   // One bit time on the line; idle level is high
   task automatic bitOut(input logic b);
      serialInPin <= b;
      repeat (BIT) @(posedge clk);
   endtask : bitOut
   // Start, data LSB first, parity, stop, then one more high bit
   task automatic send(input logic [7:0] d, input logic p, input logic useP, input logic bad);
      bitOut(1'b0);
      for (int i = 0; i < 8; i++) bitOut(d[i]);
      if (useP) bitOut(p);
      bitOut(!bad);
      bitOut(1'b1);
   endtask : send
   // Mid-bit capture of ten bits after a falling start edge
   always begin
      @(negedge serialOutPin);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (BIT) @(posedge clk);
         got[i] = serialOutPin;
      end
      gotCnt++;
   end
endmodule : asp_remote

// ### tb/asp_async_port_tb.sv
module asp_async_port_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 208; // 16 ticks of 13 clocks
   localparam logic [15:0] A_C1 = {asp_pkg::IDX_CTRL_ONE, 2'b00};
   localparam logic [15:0] A_ST = {asp_pkg::IDX_STATUS, 2'b00};
   localparam logic [15:0] A_C2 = {asp_pkg::IDX_CTRL_TWO, 2'b00};
   localparam logic [15:0] A_BUF = {asp_pkg::IDX_BUFFER, 2'b00};
   logic        clk = 1'b0, rst = 1'b1, serIn, serOut, txIrq, rxIrq;
   logic [15:0] awaddr = 16'h0, araddr = 16'h0, seed = 16'h5384;
   logic [31:0] wdata = 32'h0, rdata;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rs;
   logic [7:0]  d;
   logic [7:0]  ctl [3] = '{8'h80, 8'h98, 8'ha8};
   int          fails = 0, comparisons = 0, n, k;
   logic [3:0]  tc = 4'h0;
   logic        tmr = 1'b0;
   always #5 clk = ~clk;
   // Timer pulse every 13 clocks, so code 110 keeps the same bit time as /13
   always @(posedge clk) begin
      tc  <= (tc == 4'hc) ? 4'h0 : tc + 4'h1;
      tmr <= (tc == 4'hc);
   end
   asp_async_port dut (.clk, .rst, .ce(1'b1), .timerFive(tmr), .serialInPin(serIn),
      .serialOutPin(serOut), .txEventIrq(txIrq), .rxEventIrq(rxIrq), .awaddr, .awprot(3'h0),
      .awvalid, .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready,
      .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
   asp_remote #(.BIT(BIT)) rem (.clk, .serialOutPin(serOut), .serialInPin(serIn));
   task automatic close_out;
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : close_out
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      fails++;
      $display("FAIL %0t timeout", $time);
      close_out();
   endtask : hang
   // Write: address and data offered together, each dropped once taken
   task automatic axw(input logic [15:0] a, input logic [31:0] dt);
      @(posedge clk);
      awaddr <= a;
      wdata <= dt;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      if (k == 100) hang();
      chk({30'h0, bresp}, {30'h0, asp_pkg::RESP_OKAY});
   endtask : axw
   // Read and compare; reads have side effects, so each is deliberate
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (k = 0; k < 100; k++) begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      rs = rresp;
      if (k == 100) hang();
      chk(rdata, exp);
   endtask : rd
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   function automatic logic parBit(input logic [7:0] x, input int m);
      return (m == 1) ? ^x : ~^x;
   endfunction : parBit
   // Bits after start: data, then parity or stop, then stop or idle
   function automatic logic [9:0] expFrame(input logic [7:0] x, input int m);
      return (m == 0) ? {2'b11, x} : {1'b1, parBit(x, m), x};
   endfunction : expFrame
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      // Buffer write before any status read; a started frame would be counted
      axw(A_C1, 32'h80);
      axw(A_BUF, 32'h5a);
      repeat (BIT * 12) @(posedge clk);
      chk(32'(rem.gotCnt), 32'h0);
      rd(A_ST, 32'h0c);
      rd(16'h0000, 32'h0);
      chk({30'h0, rs}, {30'h0, asp_pkg::RESP_SLVERR});
      rd(A_ST, 32'h0c);
      // Transmit in each format: plain, even parity, odd parity two stops
      for (int m = 0; m < 3; m++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         n = rem.gotCnt;
         axw(A_C1, {24'h0, ctl[m]});
         rd(A_ST, 32'h0c);
         axw(A_BUF, {24'h0, d});
         rd(A_ST, 32'h04);
         for (k = 0; k < 4000 && rem.gotCnt == n; k++) @(posedge clk);
         if (k == 4000) hang();
         chk({22'h0, rem.got}, {22'h0, expFrame(d, m)});
         repeat (BIT * 3) @(posedge clk);
         rd(A_ST, 32'h0c);
      end
      // Receive: good, bad parity, bad stop
      axw(A_C2, 32'h1);
      for (int m = 0; m < 3; m++) begin
         seed = lfsr(seed);
         d = seed[7:0];
         axw(A_C1, {24'h0, ctl[m] | 8'h40});
         rem.send(d, parBit(d, m) ^ (m == 1), m != 0, m == 2);
         rd(A_ST, {24'h0, 8'h1c | (m == 1 ? 8'h80 : 8'h00) | (m == 2 ? 8'h40 : 8'h00)});
         rd(A_BUF, {24'h0, d});
         rd(A_ST, 32'h0c);
      end
      // Overrun: later characters dropped until cleared
      axw(A_C1, 32'h46);
      rem.send(8'h11, 1'b0, 1'b0, 1'b0);
      rem.send(8'h22, 1'b0, 1'b0, 1'b0);
      rem.send(8'h33, 1'b0, 1'b0, 1'b0);
      rd(A_ST, 32'h3c);
      rd(A_BUF, 32'h11);
      rd(A_ST, 32'h0c);
      rem.send(8'h44, 1'b0, 1'b0, 1'b0);
      rd(A_ST, 32'h1c);
      rd(A_BUF, 32'h44);
      // Overrun raised after the status read survives the buffer read
      rem.send(8'h55, 1'b0, 1'b0, 1'b0);
      rd(A_ST, 32'h1c);
      rem.send(8'h66, 1'b0, 1'b0, 1'b0);
      rd(A_BUF, 32'h55);
      rd(A_ST, 32'h2c);
      rd(A_BUF, 32'h55);
      rd(A_ST, 32'h0c);
      close_out();
   end
endmodule : asp_async_port_tb
